// ===== safb_pkg.sv
package safb_pkg;

   // Frame layout on the link
   localparam int          WORD_BITS   = 16;
   localparam int          CMD_RW_BIT  = 15;
   localparam int          ADDR_MSB    = 14;
   localparam int          ADDR_LSB    = 8;
   localparam int          SYNC_STAGES = 2;

   // Register offsets (byte address carried in the command word)
   localparam logic [6:0]  ADDR_SYSTEM_ERROR_FLAGS = 7'h08;
   localparam logic [6:0]  ADDR_SELF_TEST_RESULT   = 7'h0a;
   localparam logic [6:0]  ADDR_SENSOR_ALARM_FLAGS = 7'h0c;

   localparam logic [15:0] REG_RESET = 16'h0000;

   // system_error_flags bit positions
   localparam int SE_WATCHDOG   = 15;
   localparam int SE_DIVERGED   = 13;
   localparam int SE_GYRO_SAT   = 12;
   localparam int SE_MAG_DIST   = 11;
   localparam int SE_ACCEL_DIST = 10;
   localparam int SE_BARO_NEW   = 9;
   localparam int SE_MAG_NEW    = 8;
   localparam int SE_OVERRUN    = 7;
   localparam int SE_FLASH_FAIL = 6;
   localparam int SE_SELF_TEST  = 5;
   localparam int SE_OVERRANGE  = 4;
   localparam int SE_LINK_ERR   = 3;
   localparam int SE_ALARM      = 0;

   // Bits held in flops (summary bits 5 and 0 are derived)
   localparam logic [15:0] SE_STORE_MASK = 16'hbfd8;
   // Error bits cleared by a read of system_error_flags
   localparam logic [15:0] SE_READ_CLEAR = 16'hbc58;
   // Every defined bit of system_error_flags
   localparam logic [15:0] SE_USED_MASK  = 16'hbff9;

   // Per-sensor layout shared by self-test and alarm registers
   localparam logic [15:0] SENSOR_MASK   = 16'h0f3f;
   localparam logic [15:0] ST_CMD_MASK   = 16'h073f;
   localparam logic [15:0] ST_BARO_MASK  = 16'h0800;
   localparam logic [15:0] ALL_ONES      = 16'hffff;

   typedef struct packed {
      logic watchdog_timeout;
      logic filter_diverged;
      logic gyro_saturated;
      logic mag_disturbed;
      logic accel_disturbed;
      logic baro_new_data;
      logic mag_new_data;
      logic proc_overrun;
      logic flash_done;
      logic flash_failed;
      logic sensor_overrange;
      logic soft_reset;
      logic pressure_output_read;
      logic mag_field_output_read;
   } safb_sources_t;

   typedef struct packed {
      logic        cmd_done;
      logic        startup_done;
      logic [15:0] fail;
   } safb_self_test_t;

endpackage

// ===== safb_top.sv
// Overview of operation
// - Reading system_error_flags clears its error bits, except processing overrun bit 7 and new-data bits 9 and 8.
// - Overrun bit stays set through reads; only software reset clears it.
// - An error still present after a read clearing sets its flag again.
// - Bit 15 sets when the watchdog times out.
// - Bit 13 sets when the orientation filter diverges.
// - Bit 12 reports gyroscope saturation with reduced filter weighting.
// - Bit 11 reports magnetometer disturbance beyond its threshold.
// - Bit 10 reports acceleration disturbance beyond its threshold.
// - Bits 9 and 8 flag unread new barometer and magnetometer data.
// - Reading pressure or any magnetometer output clears its new-data bit.
// - Bit 6 holds the flash update result: one means failure.
// - Bit 5 is one whenever self_test_result is nonzero.
// - Bit 4 sets when any sensor overranges.
// - Bit 3 sets when a frame's clock count is not a multiple of 16.
// - Bit 0 is one whenever sensor_alarm_flags is nonzero.
// - Self-test failures: gyro bits 0-2, accel 3-5, mag 8-10, baro 11.
// - Self-test flags come from the start-up and commanded internal self-tests.
// - Barometer self-test bit loads only at start-up; reads of self_test_result and reset clear it.
// - Reading self_test_result returns it, then clears it to zero.
// - Alarm flags set per sensor using the self-test bit layout.
// - Reading sensor_alarm_flags returns it, then clears it to zero.
// - All three registers are zero after reset.
`timescale 1ns/10ps
`default_nettype none

module safb_top (
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_arst_n,
   input  wire logic                     i_spi_sclk,
   input  wire logic                     i_spi_cs_n,
   input  wire logic                     i_spi_mosi,
   output logic                          o_spi_miso,
   output logic                          o_spi_miso_oe_n,
   input  wire safb_pkg::safb_sources_t  i_src,
   input  wire safb_pkg::safb_self_test_t i_self_test,
   input  wire logic [15:0]              i_alarm,
   output logic [15:0]                   o_system_error_flags,
   output logic [15:0]                   o_self_test_result,
   output logic [15:0]                   o_sensor_alarm_flags
);
   import safb_pkg::*;

   function automatic logic addr_hit(input logic [15:0] word, input logic [6:0] addr);
      addr_hit = (word[CMD_RW_BIT] == 1'b0) && (word[ADDR_MSB:ADDR_LSB] == addr);
   endfunction

   // Set wins over clear for every hardware-set flag
   function automatic logic [15:0] sticky(input logic [15:0] cur,
                                          input logic [15:0] set,
                                          input logic [15:0] clr);
      sticky = (cur & ~clr) | set;
   endfunction

   // ---------------- Link clock domain (mode 3: sample rising, shift falling)
   logic        link_rst_n;
   logic [3:0]  link_bit_cnt;
   logic [15:0] link_rx_shift;
   logic [15:0] link_rx_word;
   logic        link_word_tgl;
   logic        link_bit_tgl;
   logic [15:0] link_tx_shift;
   logic [15:0] resp_word;

   // Frame select ends all per-frame state, so a stopped clock leaves nothing open
   assign link_rst_n = i_arst_n & ~i_spi_cs_n;

   always_ff @(posedge i_spi_sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_bit_cnt  <= 4'h0;
         link_rx_shift <= REG_RESET;
      end else begin
         link_bit_cnt  <= link_bit_cnt + 4'h1;
         link_rx_shift <= {link_rx_shift[WORD_BITS-2:0], i_spi_mosi};
      end
   end

   // Held word and toggles survive frame end so the system side can collect them
   always_ff @(posedge i_spi_sclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         link_rx_word  <= REG_RESET;
         link_word_tgl <= 1'b0;
         link_bit_tgl  <= 1'b0;
      end else begin
         link_bit_tgl <= ~link_bit_tgl;
         if (link_bit_cnt == 4'hf) begin
            link_rx_word  <= {link_rx_shift[WORD_BITS-2:0], i_spi_mosi};
            link_word_tgl <= ~link_word_tgl;
         end
      end
   end

   // resp_word is quiet here: it changes only a few system clocks after a word's 16th rising edge
   always_ff @(negedge i_spi_sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_tx_shift <= REG_RESET;
      end else if (link_bit_cnt == 4'h0) begin
         link_tx_shift <= resp_word;
      end else begin
         link_tx_shift <= {link_tx_shift[WORD_BITS-2:0], 1'b0};
      end
   end

   assign o_spi_miso      = link_tx_shift[WORD_BITS-1];
   assign o_spi_miso_oe_n = i_spi_cs_n;

   // ---------------- Crossings into the system clock domain
   logic [SYNC_STAGES-1:0] word_sync;
   logic [SYNC_STAGES-1:0] bit_sync;
   logic [SYNC_STAGES-1:0] cs_sync;
   logic                   word_seen;
   logic                   bit_seen;
   logic                   cs_seen;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         word_sync <= '0;
         bit_sync  <= '0;
         cs_sync   <= '1;
         word_seen <= 1'b0;
         bit_seen  <= 1'b0;
         cs_seen   <= 1'b1;
      end else begin
         word_sync <= {word_sync[0], link_word_tgl};
         bit_sync  <= {bit_sync[0], link_bit_tgl};
         cs_sync   <= {cs_sync[0], i_spi_cs_n};
         word_seen <= word_sync[1];
         bit_seen  <= bit_sync[1];
         cs_seen   <= cs_sync[1];
      end
   end

   logic word_evt;
   logic bit_evt;
   logic frame_start;
   logic frame_end;

   assign word_evt    = word_sync[1] ^ word_seen;
   assign bit_evt     = bit_sync[1] ^ bit_seen;
   assign frame_start = cs_seen & ~cs_sync[1];
   assign frame_end   = ~cs_seen & cs_sync[1];

   // Clock pulses counted here, since the link counter is wiped at frame end
   logic [3:0] frame_bits;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         frame_bits <= 4'h0;
      end else if (frame_start) begin
         frame_bits <= 4'h0;
      end else if (bit_evt) begin
         frame_bits <= frame_bits + 4'h1;
      end
   end

   logic link_err;
   assign link_err = frame_end && (frame_bits != 4'h0);

   // ---------------- Command decode
   logic rd_sys;
   logic rd_st;
   logic rd_alm;

   // link_rx_word is stable for a whole word after its toggle arrives
   assign rd_sys = word_evt && addr_hit(link_rx_word, ADDR_SYSTEM_ERROR_FLAGS);
   assign rd_st  = word_evt && addr_hit(link_rx_word, ADDR_SELF_TEST_RESULT);
   assign rd_alm = word_evt && addr_hit(link_rx_word, ADDR_SENSOR_ALARM_FLAGS);

   // ---------------- Registers
   logic [15:0] sys_err_q;
   logic [15:0] self_test_q;
   logic [15:0] alarm_q;
   logic [15:0] sys_err_word;
   logic [15:0] se_set;
   logic [15:0] se_clr;
   logic [15:0] st_upd;
   logic [15:0] st_clr;
   logic [15:0] alm_clr;

   always_comb begin
      se_set                = REG_RESET;
      se_set[SE_WATCHDOG]   = i_src.watchdog_timeout;
      se_set[SE_DIVERGED]   = i_src.filter_diverged;
      se_set[SE_GYRO_SAT]   = i_src.gyro_saturated;
      se_set[SE_MAG_DIST]   = i_src.mag_disturbed;
      se_set[SE_ACCEL_DIST] = i_src.accel_disturbed;
      se_set[SE_BARO_NEW]   = i_src.baro_new_data;
      se_set[SE_MAG_NEW]    = i_src.mag_new_data;
      se_set[SE_OVERRUN]    = i_src.proc_overrun;
      se_set[SE_FLASH_FAIL] = i_src.flash_done & i_src.flash_failed;
      se_set[SE_OVERRANGE]  = i_src.sensor_overrange;
      se_set[SE_LINK_ERR]   = link_err;
   end

   always_comb begin
      se_clr                = rd_sys ? SE_READ_CLEAR : REG_RESET;
      se_clr[SE_BARO_NEW]   = i_src.pressure_output_read;
      se_clr[SE_MAG_NEW]    = i_src.mag_field_output_read;
      se_clr[SE_OVERRUN]    = i_src.soft_reset;
      se_clr[SE_FLASH_FAIL] = se_clr[SE_FLASH_FAIL] |
                              (i_src.flash_done & ~i_src.flash_failed);
      if (i_src.soft_reset) begin
         se_clr = ALL_ONES;
      end
   end

   // Level conditions reassert in the clearing cycle itself
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sys_err_q <= REG_RESET;
      end else begin
         sys_err_q <= sticky(sys_err_q, se_set, se_clr) & SE_STORE_MASK;
      end
   end

   always_comb begin
      st_upd = REG_RESET;
      if (i_self_test.cmd_done) begin
         st_upd = st_upd | ST_CMD_MASK;
      end
      if (i_self_test.startup_done) begin
         st_upd = st_upd | ST_CMD_MASK | ST_BARO_MASK;
      end
      st_clr = (rd_st || i_src.soft_reset) ? ALL_ONES : REG_RESET;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         self_test_q <= REG_RESET;
      end else begin
         self_test_q <= sticky(self_test_q & ~st_upd,
                               i_self_test.fail & st_upd,
                               st_clr) & SENSOR_MASK;
      end
   end

   assign alm_clr = (rd_alm || i_src.soft_reset) ? ALL_ONES : REG_RESET;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         alarm_q <= REG_RESET;
      end else begin
         alarm_q <= sticky(alarm_q, i_alarm & SENSOR_MASK, alm_clr);
      end
   end

   always_comb begin
      sys_err_word               = sys_err_q;
      sys_err_word[SE_SELF_TEST] = (self_test_q != REG_RESET);
      sys_err_word[SE_ALARM]     = (alarm_q != REG_RESET);
   end

   // Reply carried out in the next frame; unmapped reads and writes answer zero
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         resp_word <= REG_RESET;
      end else if (word_evt) begin
         if (rd_sys) begin
            resp_word <= sys_err_word;
         end else if (rd_st) begin
            resp_word <= self_test_q;
         end else if (rd_alm) begin
            resp_word <= alarm_q;
         end else begin
            resp_word <= REG_RESET;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_system_error_flags <= REG_RESET;
         o_self_test_result   <= REG_RESET;
         o_sensor_alarm_flags <= REG_RESET;
      end else begin
         o_system_error_flags <= sys_err_word;
         o_self_test_result   <= self_test_q;
         o_sensor_alarm_flags <= alarm_q;
      end
   end

   // ---------------- Checks
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_arst_n);

   AST_OVERRUN_HOLDS: assert property (
      sys_err_q[SE_OVERRUN] && !i_src.soft_reset |=> sys_err_q[SE_OVERRUN])
      else $error("Overrun flag dropped without software reset");

   AST_SYS_READ_CLEARS: assert property (
      rd_sys && !i_src.soft_reset && ((se_set & SE_READ_CLEAR) == REG_RESET)
      |=> ((sys_err_q & SE_READ_CLEAR) == REG_RESET))
      else $error("Error flags survived a read");

   AST_LEVEL_RESETS: assert property (
      rd_sys && i_src.gyro_saturated |=> sys_err_q[SE_GYRO_SAT])
      else $error("Persisting saturation not set again after read");

   AST_WATCHDOG: assert property (
      i_src.watchdog_timeout |=> sys_err_word[SE_WATCHDOG] ##1 o_system_error_flags[SE_WATCHDOG])
      else $error("Watchdog timeout not flagged");

   AST_SELF_TEST_SUMMARY: assert property (
      i_self_test.cmd_done && ((i_self_test.fail & ST_CMD_MASK) != REG_RESET)
      |=> sys_err_word[SE_SELF_TEST])
      else $error("Self-test failure not summarised");

   AST_ALARM_SUMMARY: assert property (
      ((i_alarm & SENSOR_MASK) != REG_RESET) |=> sys_err_word[SE_ALARM])
      else $error("Active alarm not summarised");

   AST_BARO_STARTUP_ONLY: assert property (
      !i_self_test.startup_done && !rd_st && !i_src.soft_reset
      |=> $stable(self_test_q & ST_BARO_MASK))
      else $error("Barometer self-test bit changed outside start-up");

   AST_UNUSED_ZERO: assert property (
      ((sys_err_word & ~SE_USED_MASK) == REG_RESET) &&
      ((self_test_q & ~SENSOR_MASK) == REG_RESET) &&
      ((alarm_q & ~SENSOR_MASK) == REG_RESET))
      else $error("Unused bit set");

   AST_LINK_ERR: assert property (
      link_err |=> sys_err_q[SE_LINK_ERR])
      else $error("Partial frame not flagged");

   AST_ALARM_READ: assert property (
      rd_alm && ((i_alarm & SENSOR_MASK) == REG_RESET)
      |=> resp_word == $past(alarm_q) && alarm_q == REG_RESET)
      else $error("Alarm read did not return and clear");

   AST_DIVERGED: assert property (
      i_src.filter_diverged |=> sys_err_q[SE_DIVERGED])
      else $error("Filter divergence not flagged");

   AST_OVERRANGE: assert property (
      i_src.sensor_overrange |=> sys_err_q[SE_OVERRANGE])
      else $error("Sensor overrange not flagged");

   AST_NEW_DATA_HOLDS: assert property (
      sys_err_q[SE_BARO_NEW] && !i_src.pressure_output_read && !i_src.soft_reset
      |=> sys_err_q[SE_BARO_NEW])
      else $error("Unread barometer data flag dropped");

   AST_BARO_NEW_CLEARS: assert property (
      i_src.pressure_output_read && !i_src.baro_new_data |=> !sys_err_q[SE_BARO_NEW])
      else $error("Barometer new-data flag not cleared by pressure read");

   AST_MAG_NEW_CLEARS: assert property (
      i_src.mag_field_output_read && !i_src.mag_new_data |=> !sys_err_q[SE_MAG_NEW])
      else $error("Magnetometer new-data flag not cleared by output read");

   AST_FLASH_RESULT: assert property (
      i_src.flash_done |=> sys_err_q[SE_FLASH_FAIL] == $past(i_src.flash_failed))
      else $error("Flash result not reported");

   AST_SELF_TEST_LOAD: assert property (
      i_self_test.cmd_done
      |=> (self_test_q & ST_CMD_MASK) == ($past(i_self_test.fail) & ST_CMD_MASK))
      else $error("Commanded self-test result not loaded");

   AST_SELF_TEST_READ: assert property (
      rd_st && !i_self_test.cmd_done && !i_self_test.startup_done
      |=> resp_word == $past(self_test_q) && self_test_q == REG_RESET)
      else $error("Self-test read did not return and clear");

   AST_ALARM_SETS: assert property (
      ((i_alarm & SENSOR_MASK) != REG_RESET)
      |=> (alarm_q & $past(i_alarm) & SENSOR_MASK) == ($past(i_alarm) & SENSOR_MASK))
      else $error("Alarm level not latched");

endmodule

`default_nettype wire

// ===== safb_host.sv
`timescale 1ns/10ps
`default_nettype none

module safb_host (
   input  wire logic i_miso,
   input  wire logic i_miso_oe_n,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_mosi
);
   logic [15:0] rx;
   logic        miso_w;

   // Released line has no pull: show the inverse so a stale bit never passes
   assign miso_w = i_miso_oe_n ? ~i_miso : i_miso;

   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
      rx     = 16'h0000;
   end

   // Mode 3, clock idles high and runs only inside frames
   task automatic frame(input int nbits, input logic [15:0] word, output logic [15:0] reply);
      #3.3;
      o_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         #62.5;
         o_sclk = 1'b0;
         o_mosi = word[15 - (i % 16)];
         #62.5;
         o_sclk = 1'b1;
         rx = {rx[14:0], miso_w};
      end
      #62.5;
      o_cs_n = 1'b1;
      // Gap well above the minimum deselect time
      #200;
      reply = rx;
   endtask
endmodule

`default_nettype wire

// ===== safb_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module safb_top_tb;
   import safb_pkg::*;

   logic            clk = 1'b0;
   logic            arst_n = 1'b0;
   logic            sclk;
   logic            cs_n;
   logic            mosi;
   logic            miso;
   logic            miso_oe_n;
   safb_sources_t   src = '0;
   safb_self_test_t st_in = '0;
   logic [15:0]     alarm = 16'h0000;
   logic [15:0]     o_se;
   logic [15:0]     o_st;
   logic [15:0]     o_al;
   logic [15:0]     exp_se = 16'h0000;
   logic [15:0]     exp_st = 16'h0000;
   logic [15:0]     exp_al = 16'h0000;
   logic [15:0]     r;
   logic [15:0]     f;
   int              mismatches = 0;
   int              checked = 0;
   logic [13:0]     src_m [7] = '{14'h2000, 14'h1000, 14'h0800, 14'h0400, 14'h0200,
                                  14'h0008, 14'h0030};
   int              se_pos [7] = '{15, 13, 12, 11, 10, 4, 6};

   always #5 clk = ~clk;

   safb_top dut_u (
      .i_sys_clk            (clk),
      .i_arst_n             (arst_n),
      .i_spi_sclk           (sclk),
      .i_spi_cs_n           (cs_n),
      .i_spi_mosi           (mosi),
      .o_spi_miso           (miso),
      .o_spi_miso_oe_n      (miso_oe_n),
      .i_src                (src),
      .i_self_test          (st_in),
      .i_alarm              (alarm),
      .o_system_error_flags (o_se),
      .o_self_test_result   (o_st),
      .o_sensor_alarm_flags (o_al)
   );

   safb_host host_u (
      .i_miso      (miso),
      .i_miso_oe_n (miso_oe_n),
      .o_sclk      (sclk),
      .o_cs_n      (cs_n),
      .o_mosi      (mosi)
   );

   function automatic logic [15:0] view();
      return exp_se | {10'h000, exp_st != 16'h0000, 4'h0, exp_al != 16'h0000};
   endfunction

   task automatic wrap_up();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic pulse(input logic [13:0] s, input logic [17:0] t, input logic [15:0] a);
      @(negedge clk);
      src = s;
      st_in = t;
      alarm = a;
      @(negedge clk);
      src = '0;
      st_in = '0;
      alarm = 16'h0000;
      repeat (4) @(negedge clk);
   endtask

   // Reply arrives one frame late; a refused write fetches it
   task automatic rd(input logic [6:0] addr, output logic [15:0] val);
      logic [15:0] dummy;
      host_u.frame(16, {1'b0, addr, 8'h00}, dummy);
      host_u.frame(16, 16'h8000, val);
      @(negedge clk);
   endtask

   initial begin
      #500000;
      mismatches++;
      wrap_up();
   end

   initial begin
      void'($urandom(92));
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(o_se | o_st | o_al, REG_RESET);
      chk({15'h0000, miso_oe_n}, 16'h0001);
      rd(ADDR_SELF_TEST_RESULT, r);
      chk(r, REG_RESET);
      for (int k = 0; k < 7; k++) begin
         pulse(src_m[k], '0, 16'h0000);
         exp_se[se_pos[k]] = 1'b1;
         chk(o_se, view());
         rd(ADDR_SYSTEM_ERROR_FLAGS, r);
         chk(r, view());
         exp_se &= ~SE_READ_CLEAR;
         chk(o_se, view());
      end
      pulse(14'h0040, '0, 16'h0000);
      exp_se[SE_OVERRUN] = 1'b1;
      rd(ADDR_SYSTEM_ERROR_FLAGS, r);
      chk(r, view());
      chk(o_se, view());
      pulse(14'h0004, '0, 16'h0000);
      exp_se = 16'h0000;
      chk(o_se, view());
      src = 14'h0800;
      exp_se[SE_GYRO_SAT] = 1'b1;
      rd(ADDR_SYSTEM_ERROR_FLAGS, r);
      chk(r, view());
      chk(o_se, view());
      src = '0;
      rd(ADDR_SYSTEM_ERROR_FLAGS, r);
      exp_se = 16'h0000;
      chk(o_se, view());
      pulse(14'h0180, '0, 16'h0000);
      exp_se = 16'h0300;
      rd(ADDR_SYSTEM_ERROR_FLAGS, r);
      chk(o_se, view());
      pulse(14'h0002, '0, 16'h0000);
      exp_se[SE_BARO_NEW] = 1'b0;
      chk(o_se, view());
      pulse(14'h0001, '0, 16'h0000);
      exp_se[SE_MAG_NEW] = 1'b0;
      chk(o_se, view());
      pulse(14'h0030, '0, 16'h0000);
      pulse(14'h0020, '0, 16'h0000);
      chk(o_se, view());
      f = 16'($urandom) | 16'h0001;
      pulse('0, {2'b10, f}, 16'h0000);
      exp_st = f & ST_CMD_MASK;
      chk(o_st, exp_st);
      chk(o_se, view());
      f = 16'($urandom) | ST_BARO_MASK;
      pulse('0, {2'b01, f}, 16'h0000);
      exp_st = f & SENSOR_MASK;
      chk(o_st, exp_st);
      pulse('0, {2'b10, 16'h0000}, 16'h0000);
      exp_st &= ST_BARO_MASK;
      chk(o_st, exp_st);
      rd(ADDR_SELF_TEST_RESULT, r);
      chk(r, exp_st);
      exp_st = 16'h0000;
      chk(o_st | (o_se & 16'h0020), exp_st);
      f = 16'($urandom);
      pulse('0, '0, f);
      exp_al = f & SENSOR_MASK;
      chk(o_al, exp_al);
      pulse('0, '0, ALL_ONES);
      exp_al = SENSOR_MASK;
      chk(o_al, exp_al);
      chk(o_se, view());
      rd(ADDR_SENSOR_ALARM_FLAGS, r);
      chk(r, exp_al);
      exp_al = 16'h0000;
      chk(o_al, exp_al);
      chk(o_se, view());
      host_u.frame(15, 16'h0800, r);
      repeat (10) @(negedge clk);
      exp_se[SE_LINK_ERR] = 1'b1;
      chk(o_se, view());
      rd(ADDR_SYSTEM_ERROR_FLAGS, r);
      chk(r, view());
      exp_se = 16'h0000;
      pulse('0, '0, 16'h0001);
      exp_al = 16'h0001;
      // Refused write, then an unmapped read
      host_u.frame(16, {1'b1, ADDR_SENSOR_ALARM_FLAGS, 8'hff}, r);
      rd(7'h20, r);
      chk(r, 16'h0000);
      chk(o_al, exp_al);
      chk(o_se, view());
      wrap_up();
   end
endmodule

`default_nettype wire
